// ### verilog/can_mh_defs.svh
// Purpose: offsets, field positions and reset values of the message handler
// Assumes: 32-bit APB, one aligned word per register, data in bits 15:0
// Notes:   included by its bare name
`ifndef CAN_MH_DEFS_SVH
`define CAN_MH_DEFS_SVH

`define OBJ_COUNT   32
`define OBJ_MAX     6'h20

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFF_CRR     12'h020
`define OFF_CMR     12'h024
`define OFF_M1R     12'h028
`define OFF_M2R     12'h02C
`define OFF_A1R     12'h030
`define OFF_A2R     12'h034
`define OFF_MCR     12'h038
`define OFF_DA1     12'h03C
`define OFF_DA2     12'h040
`define OFF_DB1     12'h044
`define OFF_DB2     12'h048
`define OFF_TXR1    12'h100
`define OFF_TXR2    12'h104
`define OFF_ND1     12'h120
`define OFF_ND2     12'h124
`define OFF_IP1     12'h140
`define OFF_IP2     12'h144
`define OFF_MV1     12'h160
`define OFF_MV2     12'h164
`define OFF_IDR     12'h180

// ----------------------------------------------------------------------
// command mask bits
// ----------------------------------------------------------------------
`define CMR_WRITE   7
`define CMR_MASK    6
`define CMR_ARB     5
`define CMR_CTRL    4
`define CMR_CLRINT  3
`define CMR_TXRQ    2
`define CMR_DATA_A  1
`define CMR_DATA_B  0

`define CMR_RESET   8'h00
`define M2R_RSV     1'h1

`endif

// ### verilog/can_mh_pkg.sv
// Purpose: types of the message handler
// Assumes: nothing
// Notes:   object groups match the command mask groups
package can_mh_pkg;

  typedef struct packed {
    logic        mask_extended_select;
    logic        mask_direction_select;
    logic [28:0] identifier_mask_field;
  } mask_grp_type;

  typedef struct packed {
    logic        object_valid_flag;
    logic        ext_id;
    logic        dir_transmit;
    logic [28:0] identifier_field;
  } arb_grp_type;

  typedef struct packed {
    logic        fresh_data_flag;
    logic        overrun_lost_flag;
    logic        pending_interrupt_flag;
    logic        use_mask_enable;
    logic        send_interrupt_enable;
    logic        receive_interrupt_enable;
    logic        remote_answer_enable;
    logic        send_request_flag;
    logic        end_of_block_flag;
    logic [3:0]  length_code_field;
  } ctl_grp_type;

  typedef struct packed {
    mask_grp_type mask;
    arb_grp_type  arb;
    ctl_grp_type  ctl;
    logic [31:0]  da;
    logic [31:0]  db;
  } obj_type;

  typedef struct packed {
    logic [28:0] identifier_field;
    logic        ext_id;
    logic        remote_frame;
    logic [3:0]  length_code_field;
    logic [63:0] data;
  } frame_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XFER_RD,
    ST_XFER_WR,
    ST_SCAN,
    ST_STORE
  } mh_state_type;

endpackage

// ### verilog/can_message_handler.sv
// Purpose: message handler: interface set, message RAM, tx select, rx filter
// Assumes: protocol core runs on clk; its strobes are one-cycle pulses
// Notes:   one interface register set; objects held in flip-flops
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/10ps
`include "can_mh_defs.svh"

// What this block does
// - busy flag set during interface transfer
// - mask selects parts; writes are read-modify-write
// - partial write refreshes unselected buffer parts
// - load best pending object, clear fresh data
// - clear send request unless fresh data
// - send interrupt enable sets pending interrupt
// - failed send retried in priority order
// - scan objects upward from one on header
// - store data, arbitration and length code
// - set fresh data, overrun if already set
// - receive interrupt enable sets pending interrupt
// - stored data frame clears send request
// - remote frame sets request or ignored
// - remote frame with mask stores header
// - lower object number wins priority
// - remote answer only with remote enable set
// - data-only update also sets send request
// - fresh data with request survives transmission
// - updates accepted without clearing valid flags
module can_message_handler
  import can_mh_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        core_tx_ready,
  input  wire logic        core_tx_ok,
  input  wire logic        core_tx_fail,
  output logic             tx_load,
  output frame_type        tx_frame,
  input  wire logic        rx_hdr_valid,
  input  wire logic        rx_done,
  input  wire frame_type   rx_frame
);

  // ----------------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------------
  obj_type      ram_reg [0:`OBJ_COUNT-1];
  obj_type      buf_reg;
  obj_type      buf_next;
  obj_type      tmp_reg;
  obj_type      merged_wr;
  obj_type      merged_rd;
  logic [7:0]   cmr_reg;
  logic [5:0]   crr_num_reg;
  logic         busy_reg;
  mh_state_type state_reg;
  frame_type    hdr_reg;
  frame_type    rxf_reg;
  logic         scan_pend_reg;
  logic         store_pend_reg;
  logic         match_found_reg;
  logic [4:0]   scan_idx_reg;
  logic [4:0]   match_idx_reg;
  logic         tx_busy_reg;
  logic         txok_pend_reg;
  logic [4:0]   tx_idx_reg;

  logic [31:0]  valid_vec;
  logic [31:0]  txrq_vec;
  logic [31:0]  fresh_data_flag_vec;
  logic [31:0]  pending_interrupt_flag_vec;
  logic [15:0]  rd_word;
  logic         rd_hit;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic obj_type merge(obj_type s, obj_type u, logic [7:0] m);
    obj_type r;
    r = u;
    if (m[`CMR_MASK])
      r.mask = s.mask;
    if (m[`CMR_ARB])
      r.arb = s.arb;
    if (m[`CMR_CTRL])
      r.ctl = s.ctl;
    if (m[`CMR_DATA_A])
      r.da = s.da;
    if (m[`CMR_DATA_B])
      r.db = s.db;
    return r;
  endfunction

  // object number of lowest set bit, zero when none
  function automatic logic [5:0] first_set(logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i])
        n = 6'(i + 1);
    end
    return n;
  endfunction

  function automatic logic accept(obj_type o, frame_type h);
    logic [28:0] m;
    logic        xok;
    logic        dok;
    m = o.ctl.use_mask_enable ? o.mask.identifier_mask_field : 29'h1FFFFFFF;
    if (!h.ext_id)
      m = m & 29'h1FFC0000;
    xok = (o.arb.ext_id == h.ext_id) |
          (o.ctl.use_mask_enable & ~o.mask.mask_extended_select);
    dok = (o.arb.dir_transmit == h.remote_frame) |
          (o.ctl.use_mask_enable & ~o.mask.mask_direction_select);
    return o.arb.object_valid_flag & xok & dok &
           (((o.arb.identifier_field ^ h.identifier_field) & m) == 29'h0);
  endfunction

  // ----------------------------------------------------------------------
  // per-object flag vectors
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `OBJ_COUNT; g++) begin : g_vec
      assign valid_vec[g]  = ram_reg[g].arb.object_valid_flag;
      assign txrq_vec[g]   = ram_reg[g].ctl.send_request_flag;
      assign fresh_data_flag_vec[g] = ram_reg[g].ctl.fresh_data_flag;
      assign pending_interrupt_flag_vec[g] = ram_reg[g].ctl.pending_interrupt_flag;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // decode and selection
  // ----------------------------------------------------------------------
  wire        setup     = psel & ~penable;
  wire        bus_wr    = psel & penable & pready & pwrite;
  wire        buf_wr    = bus_wr & ~busy_reg;
  wire [4:0]  xfer_idx  = 5'(crr_num_reg - 6'h01);
  wire        crr_ok    = (pwdata[5:0] != 6'h00) & (pwdata[5:0] <= `OBJ_MAX);
  wire        is_idle   = (state_reg == ST_IDLE);
  wire        rx_ready  = is_idle & store_pend_reg & ~scan_pend_reg;
  wire        store_go  = rx_ready & match_found_reg;
  wire        scan_hit  = accept(ram_reg[scan_idx_reg], hdr_reg);
  wire        scan_last = (scan_idx_reg == 5'h1F);
  wire [5:0]  tx_num    = first_set(valid_vec & txrq_vec);
  wire [4:0]  tx_sel    = 5'(tx_num - 6'h01);
  wire [5:0]  int_num   = first_set(pending_interrupt_flag_vec);
  wire        tx_start  = is_idle & ~store_pend_reg & ~scan_pend_reg &
                          ~busy_reg & core_tx_ready & ~tx_busy_reg &
                          ~txok_pend_reg & (tx_num != 6'h00);
  wire        txok_done = txok_pend_reg & (is_idle | (state_reg == ST_SCAN));
  wire        xfer_wr   = (state_reg == ST_XFER_WR);
  wire        xfer_dir  = cmr_reg[`CMR_WRITE];
  obj_type    st_obj;
  assign st_obj = ram_reg[match_idx_reg];

  assign merged_wr = merge(buf_reg, tmp_reg, cmr_reg);
  assign merged_rd = merge(tmp_reg, buf_reg, cmr_reg);

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 16'h0000;
    if (paddr == `OFF_CRR)
      rd_word = {busy_reg, 9'h000, crr_num_reg};
    else if (paddr == `OFF_CMR)
      rd_word = {8'h00, cmr_reg};
    else if (paddr == `OFF_M1R)
      rd_word = buf_reg.mask[15:0];
    else if (paddr == `OFF_M2R)
      rd_word = {buf_reg.mask[30:29], `M2R_RSV, buf_reg.mask[28:16]};
    else if (paddr == `OFF_A1R)
      rd_word = buf_reg.arb[15:0];
    else if (paddr == `OFF_A2R)
      rd_word = buf_reg.arb[31:16];
    else if (paddr == `OFF_MCR)
      rd_word = {buf_reg.ctl[12:4], 3'h0, buf_reg.ctl[3:0]};
    else if (paddr == `OFF_DA1)
      rd_word = buf_reg.da[15:0];
    else if (paddr == `OFF_DA2)
      rd_word = buf_reg.da[31:16];
    else if (paddr == `OFF_DB1)
      rd_word = buf_reg.db[15:0];
    else if (paddr == `OFF_DB2)
      rd_word = buf_reg.db[31:16];
    else if (paddr == `OFF_TXR1)
      rd_word = txrq_vec[15:0];
    else if (paddr == `OFF_TXR2)
      rd_word = txrq_vec[31:16];
    else if (paddr == `OFF_ND1)
      rd_word = fresh_data_flag_vec[15:0];
    else if (paddr == `OFF_ND2)
      rd_word = fresh_data_flag_vec[31:16];
    else if (paddr == `OFF_IP1)
      rd_word = pending_interrupt_flag_vec[15:0];
    else if (paddr == `OFF_IP2)
      rd_word = pending_interrupt_flag_vec[31:16];
    else if (paddr == `OFF_MV1)
      rd_word = valid_vec[15:0];
    else if (paddr == `OFF_MV2)
      rd_word = valid_vec[31:16];
    else if (paddr == `OFF_IDR)
      rd_word = {10'h000, int_num};
    else
      rd_hit = 1'b0;
  end

  always_comb begin
    buf_next = buf_reg;
    if (xfer_wr) begin
      buf_next = xfer_dir ? merged_wr : merged_rd;
    end else if (buf_wr) begin
      if (paddr == `OFF_M1R)
        buf_next.mask[15:0] = pwdata[15:0];
      else if (paddr == `OFF_M2R)
        buf_next.mask[30:16] = {pwdata[15:14], pwdata[12:0]};
      else if (paddr == `OFF_A1R)
        buf_next.arb[15:0] = pwdata[15:0];
      else if (paddr == `OFF_A2R)
        buf_next.arb[31:16] = pwdata[15:0];
      else if (paddr == `OFF_MCR)
        buf_next.ctl = {pwdata[15:7], pwdata[3:0]};
      else if (paddr == `OFF_DA1)
        buf_next.da[15:0] = pwdata[15:0];
      else if (paddr == `OFF_DA2)
        buf_next.da[31:16] = pwdata[15:0];
      else if (paddr == `OFF_DB1)
        buf_next.db[15:0] = pwdata[15:0];
      else if (paddr == `OFF_DB2)
        buf_next.db[31:16] = pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ~rd_hit;
      if (setup)
        prdata <= {16'h0000, rd_word};
    end
  end

  // ----------------------------------------------------------------------
  // interface register set
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_reg     <= '0;
      tmp_reg     <= '0;
      cmr_reg     <= `CMR_RESET;
      crr_num_reg <= 6'h01;
      busy_reg    <= 1'b0;
    end else if (ce) begin
      buf_reg <= buf_next;
      if (state_reg == ST_XFER_RD)
        tmp_reg <= ram_reg[xfer_idx];
      if (buf_wr & (paddr == `OFF_CMR))
        cmr_reg <= pwdata[7:0];
      if (buf_wr & (paddr == `OFF_CRR) & crr_ok) begin
        crr_num_reg <= pwdata[5:0];
        busy_reg    <= 1'b1;
      end else if (xfer_wr) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // handler state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          if (store_go)
            state_reg <= ST_STORE;
          else if (scan_pend_reg)
            state_reg <= ST_SCAN;
          else if (busy_reg)
            state_reg <= ST_XFER_RD;
        end
        ST_XFER_RD:
          state_reg <= ST_XFER_WR;
        ST_SCAN: begin
          if (scan_hit | scan_last | rx_hdr_valid)
            state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // acceptance scan
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hdr_reg         <= '0;
      rxf_reg         <= '0;
      scan_pend_reg   <= 1'b0;
      store_pend_reg  <= 1'b0;
      match_found_reg <= 1'b0;
      scan_idx_reg    <= 5'h00;
      match_idx_reg   <= 5'h00;
    end else if (ce) begin
      if (rx_hdr_valid) begin
        hdr_reg         <= rx_frame;
        scan_pend_reg   <= 1'b1;
        match_found_reg <= 1'b0;
      end else if (is_idle & ~store_go & scan_pend_reg) begin
        scan_pend_reg <= 1'b0;
        scan_idx_reg  <= 5'h00;
      end else if (state_reg == ST_SCAN) begin
        if (scan_hit) begin
          match_found_reg <= 1'b1;
          match_idx_reg   <= scan_idx_reg;
        end else if (!scan_last) begin
          scan_idx_reg <= scan_idx_reg + 5'h01;
        end
      end
      if (rx_done) begin
        rxf_reg        <= rx_frame;
        store_pend_reg <= 1'b1;
      end else if (rx_ready) begin
        store_pend_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmit control
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_load       <= 1'b0;
      tx_frame      <= '0;
      tx_busy_reg   <= 1'b0;
      txok_pend_reg <= 1'b0;
      tx_idx_reg    <= 5'h00;
    end else if (ce) begin
      tx_load <= tx_start;
      if (tx_start) begin
        tx_frame.identifier_field  <= ram_reg[tx_sel].arb.identifier_field;
        tx_frame.ext_id            <= ram_reg[tx_sel].arb.ext_id;
        tx_frame.remote_frame      <= ~ram_reg[tx_sel].arb.dir_transmit;
        tx_frame.length_code_field <= ram_reg[tx_sel].ctl.length_code_field;
        tx_frame.data              <= {ram_reg[tx_sel].db, ram_reg[tx_sel].da};
        tx_idx_reg                 <= tx_sel;
        tx_busy_reg                <= 1'b1;
      end else if (tx_busy_reg & (core_tx_ok | core_tx_fail)) begin
        tx_busy_reg <= 1'b0;
      end
      if (tx_busy_reg & core_tx_ok)
        txok_pend_reg <= 1'b1;
      else if (txok_done)
        txok_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // message RAM
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `OBJ_COUNT; i++)
        ram_reg[i] <= '0;
    end else if (ce) begin
      if (tx_start)
        ram_reg[tx_sel].ctl.fresh_data_flag <= 1'b0;
      if (txok_done) begin
        if (!ram_reg[tx_idx_reg].ctl.fresh_data_flag)
          ram_reg[tx_idx_reg].ctl.send_request_flag <= 1'b0;
        if (ram_reg[tx_idx_reg].ctl.send_interrupt_enable)
          ram_reg[tx_idx_reg].ctl.pending_interrupt_flag <= 1'b1;
      end
      if (xfer_wr & xfer_dir) begin
        ram_reg[xfer_idx] <= merged_wr;
        if (cmr_reg[`CMR_TXRQ])
          ram_reg[xfer_idx].ctl.send_request_flag <= 1'b1;
      end else if (xfer_wr) begin
        if (cmr_reg[`CMR_CLRINT])
          ram_reg[xfer_idx].ctl.pending_interrupt_flag <= 1'b0;
        if (cmr_reg[`CMR_TXRQ])
          ram_reg[xfer_idx].ctl.fresh_data_flag <= 1'b0;
      end
      if ((state_reg == ST_STORE) & ~rxf_reg.remote_frame) begin
        ram_reg[match_idx_reg].arb.identifier_field <= rxf_reg.identifier_field;
        ram_reg[match_idx_reg].arb.ext_id <= rxf_reg.ext_id;
        ram_reg[match_idx_reg].ctl.length_code_field <= rxf_reg.length_code_field;
        ram_reg[match_idx_reg].da <= rxf_reg.data[31:0];
        ram_reg[match_idx_reg].db <= rxf_reg.data[63:32];
        ram_reg[match_idx_reg].ctl.fresh_data_flag <= 1'b1;
        if (st_obj.ctl.fresh_data_flag)
          ram_reg[match_idx_reg].ctl.overrun_lost_flag <= 1'b1;
        if (st_obj.ctl.receive_interrupt_enable)
          ram_reg[match_idx_reg].ctl.pending_interrupt_flag <= 1'b1;
        ram_reg[match_idx_reg].ctl.send_request_flag <= 1'b0;
      end else if ((state_reg == ST_STORE) & st_obj.arb.dir_transmit) begin
        if (st_obj.ctl.remote_answer_enable) begin
          ram_reg[match_idx_reg].ctl.send_request_flag <= 1'b1;
        end else if (st_obj.ctl.use_mask_enable) begin
          ram_reg[match_idx_reg].ctl.send_request_flag <= 1'b0;
          ram_reg[match_idx_reg].arb.identifier_field <= rxf_reg.identifier_field;
          ram_reg[match_idx_reg].arb.ext_id <= rxf_reg.ext_id;
          ram_reg[match_idx_reg].ctl.length_code_field <= rxf_reg.length_code_field;
          ram_reg[match_idx_reg].ctl.fresh_data_flag <= 1'b1;
        end
      end
    end
  end

endmodule

// ### sim/can_mh_checker.sv
// Purpose: port assertions of the message handler
// Assumes: core strobes last one cycle
// Notes:   bound to every handler instance
`timescale 1ns/10ps
module can_mh_checker
  import can_mh_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_tx_ready,
  input wire logic        core_tx_ok,
  input wire logic        core_tx_fail,
  input wire logic        tx_load,
  input wire frame_type   tx_frame
);
  // ------------------------------------------------------------
  // frame in flight and properties
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic fly_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) fly_reg <= 1'b0;
    else if (tx_load) fly_reg <= 1'b1;
    else if (core_tx_ok || core_tx_fail) fly_reg <= 1'b0;
  end
  sequence setup_s; $rose(penable) && psel && ce; endsequence
  sequence retry_s; ##[1:100] tx_load; endsequence
  a_zero_wait: assert property (setup_s |-> pready)
    else $error("access without ready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_error_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_load_cause: assert property (tx_load |-> $past(core_tx_ready) && !fly_reg)
    else $error("load while core busy");
  a_load_pulse: assert property (tx_load |=> !tx_load)
    else $error("load longer than one cycle");
  a_frame_stands: assert property (!tx_load |-> $stable(tx_frame))
    else $error("frame changed without load");
  a_fail_retry: assert property (core_tx_fail |-> retry_s)
    else $error("no resend after failure");
endmodule

bind can_message_handler can_mh_checker u_chk (.clk, .arst_n, .ce, .psel, .penable,
  .pready, .pslverr, .core_tx_ready, .core_tx_ok, .core_tx_fail, .tx_load, .tx_frame);

// ### sim/can_core_model.sv
// Purpose: protocol core stand-in with remote nodes
// Assumes: frames answered answer_delay plus two cycles after load
// Notes:   receive task called by the bench
`timescale 1ns/10ps
module can_core_model
  import can_mh_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       tx_load,
  input  wire logic       stall,
  input  wire logic       fail_next,
  input  wire logic [3:0] answer_delay,
  output logic            core_tx_ready,
  output logic            core_tx_ok,
  output logic            core_tx_fail,
  output logic            rx_hdr_valid,
  output logic            rx_done,
  output frame_type       rx_frame
);
  // ------------------------------------------------------------
  // transmit side
  // ------------------------------------------------------------
  logic       idle_reg;
  logic [3:0] wait_reg;
  assign core_tx_ready = idle_reg && !stall;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_reg <= 1'b1;
      wait_reg <= 4'h0;
      core_tx_ok <= 1'b0;
      core_tx_fail <= 1'b0;
    end else begin
      core_tx_ok <= 1'b0;
      core_tx_fail <= 1'b0;
      if (tx_load) begin
        idle_reg <= 1'b0;
        wait_reg <= answer_delay;
      end else if (!idle_reg) begin
        wait_reg <= wait_reg - 4'h1;
        if (wait_reg == 4'h0) begin
          idle_reg <= 1'b1;
          core_tx_ok <= !fail_next;
          core_tx_fail <= fail_next;
        end
      end
    end
  end
  initial begin
    rx_hdr_valid = 1'b0;
    rx_done = 1'b0;
    rx_frame = '0;
  end
  task automatic receive(input frame_type f);
    @(posedge clk);
    rx_frame <= f;
    rx_hdr_valid <= 1'b1;
    @(posedge clk);
    rx_hdr_valid <= 1'b0;
    repeat (40) @(posedge clk);
    rx_done <= 1'b1;
    @(posedge clk);
    rx_done <= 1'b0;
    rx_frame <= ~f;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ### sim/can_message_handler_tb.sv
// Purpose: self-checking bench of the message handler
// Assumes: core model on the far side, ce held high
// Notes:   objects 2 and 3 transmit, object 5 receives
`timescale 1ns/10ps
`include "can_mh_defs.svh"
module can_message_handler_tb
  import can_mh_pkg::*;
;
  // ------------------------------------------------------------
  // signals, instances, tasks
  // ------------------------------------------------------------
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        stall, fail_next, tx_load, core_tx_ready, core_tx_ok, core_tx_fail;
  logic        rx_hdr_valid, rx_done;
  logic [3:0]  answer_delay;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  frame_type   tx_frame, rx_frame, frames[$];
  int          bad_count, samples_checked, cyc;

  can_message_handler u_dut (.clk, .arst_n, .ce(1'b1), .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .core_tx_ready, .core_tx_ok, .core_tx_fail,
    .tx_load, .tx_frame, .rx_hdr_valid, .rx_done, .rx_frame);
  can_core_model u_core (.clk, .arst_n, .tx_load, .stall, .fail_next, .answer_delay,
    .core_tx_ready, .core_tx_ok, .core_tx_fail, .rx_hdr_valid, .rx_done, .rx_frame);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_load === 1'b1) frames.push_back(tx_frame);
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
    apb(a, 1'b0, 32'h0);
    check(what, rv, e);
  endtask
  task automatic xfer(input logic [7:0] m, input logic [5:0] n);
    apb(`OFF_CMR, 1'b1, {24'h0, m});
    apb(`OFF_CRR, 1'b1, {26'h0, n});
    rd(`OFF_CRR, {16'h0, 1'b1, 9'h0, n}, "busy set");
    repeat (6) if (rv[15] === 1'b1) apb(`OFF_CRR, 1'b0, 32'h0);
    check("busy clear", rv, {26'h0, n});
  endtask
  task automatic obj(input logic [5:0] n, input logic [7:0] m, input logic [15:0] a2, c,
                     input logic [31:0] d);
    apb(`OFF_A2R, 1'b1, {16'h0, a2});
    apb(`OFF_MCR, 1'b1, {16'h0, c});
    for (int i = 0; i < 4; i++)
      apb(`OFF_DA1 + 12'(4 * i), 1'b1, {16'h0, i[0] ? d[31:16] : d[15:0]});
    xfer(m, n);
  endtask
  function automatic frame_type fr(input logic [12:0] x, input logic rem);
    return {x, 16'h0, 1'b0, rem, 4'h8, 64'hA5A5_0F0F_1234_5678};
  endfunction

  initial begin
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {stall, fail_next, answer_delay} = {2'b11, 4'h1};
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd(`OFF_CRR, 32'h1, "number");
    rd(`OFF_M2R, 32'h2000, "mask two");
    rd(12'h0FC, 32'h0, "gap");
    check("slverr", {31'h0, err}, 32'h1);
    $display("test registers done");
    obj(6'h03, 8'hF3, 16'hA010, 16'h0888, 32'h1111_2222);
    obj(6'h02, 8'hF3, 16'hA008, 16'h0888, 32'h3333_4444);
    obj(6'h02, 8'h87, 16'h0000, 16'h0000, 32'h7777_8888);
    obj(6'h03, 8'h97, 16'h0000, 16'h8988, 32'h5555_6666);
    rd(`OFF_A2R, 32'hA010, "merged arb");
    rd(`OFF_TXR1, 32'h6, "requests");
    rd(`OFF_ND1, 32'h4, "fresh");
    stall <= 1'b0;
    wait (core_tx_fail === 1'b1);
    fail_next <= 1'b0;
    answer_delay <= 4'h9;
    wait (frames.size() == 3);
    repeat (20) @(posedge clk);
    check("first id", 32'(frames[0].identifier_field), 32'h0008_0000);
    check("first data", frames[0].data[63:32], 32'h7777_8888);
    check("retry id", 32'(frames[1].identifier_field), 32'h0008_0000);
    check("third id", 32'(frames[2].identifier_field), 32'h0010_0000);
    check("third data", frames[2].data[31:0], 32'h5555_6666);
    rd(`OFF_TXR1, 32'h0, "sent");
    rd(`OFF_IP1, 32'h6, "tx pending");
    rd(`OFF_ND1, 32'h0, "fresh gone");
    rd(`OFF_IDR, 32'h2, "int id");
    $display("test transmit done");
    stall <= 1'b1;
    obj(6'h05, 8'hF3, 16'h8020, 16'h0588, 32'h0);
    u_core.receive(fr(13'h0020, 1'b0));
    u_core.receive(fr(13'h0020, 1'b0));
    rd(`OFF_ND1, 32'h10, "rx fresh");
    rd(`OFF_IP1, 32'h16, "rx pending");
    xfer(8'h7F, 6'h05);
    rd(`OFF_MCR, 32'hE488, "rx control");
    rd(`OFF_DA1, 32'h5678, "rx low");
    rd(`OFF_DB2, 32'hA5A5, "rx high");
    rd(`OFF_ND1, 32'h0, "rx read");
    $display("test receive done");
    u_core.receive(fr(13'h0010, 1'b1));
    rd(`OFF_TXR1, 32'h0, "ignored");
    obj(6'h02, 8'h90, 16'h0000, 16'h0A88, 32'h0);
    rd(`OFF_DA1, 32'h8888, "kept data");
    u_core.receive(fr(13'h0008, 1'b1));
    rd(`OFF_TXR1, 32'h2, "remote");
    obj(6'h03, 8'h90, 16'h0000, 16'h1988, 32'h0);
    u_core.receive(fr(13'h0030, 1'b1));
    rd(`OFF_TXR1, 32'h2, "mask remote");
    rd(`OFF_ND1, 32'h4, "mask fresh");
    stall <= 1'b0;
    wait (frames.size() == 4);
    check("answer", {31'h0, frames[3].remote_frame}, 32'h0);
    $display("test remote done");
    results();
  end
endmodule
